// ---- rtl/serial_rx_message_framer.sv ----
// receive message framer: start patterns, end conditions, response timeout
// assumes characters arrive as one-cycle strobes from a receiver on pclk
//
// Local design decisions: the register addresses and register access over APB.
`timescale 1ns/1ns
module serial_rx_message_framer
  import rx_framer_pkg::*;
#(
  parameter int          MS_DIV      = MS_CYCLES,
  parameter logic [15:0] BIT_DIV_RST = 16'h00a6,
  parameter int          DEPTH       = 1024
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic        srst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_data,
  input  wire logic        tx_done,
  output logic             rx_busy,
  output logic             msg_done,
  output logic             msg_error
);
  localparam int AW = $clog2(DEPTH);
  state_e                    state_r;
  ctrl_s                     ctrl_r;
  seq_s  [SEQ_NUM-1:0]       seq_r;
  logic  [15:0]              msg_to_r;
  logic  [15:0]              resp_to_r;
  logic  [15:0]              gap_r;
  logic  [9:0]               max_len_r;
  logic  [15:0]              bit_div_r;
  logic  [15:0]              idle_bits_r;
  logic  [AW-1:0]            rd_idx_r;
  logic  [7:0]               mem [0:DEPTH-1];
  logic  [7:0]               rd_data_r;
  logic                      done_r;
  logic                      err_r;
  logic  [2:0]               cause_r;
  logic  [9:0]               len_r;
  logic  [SEQ_CHARS-1:0][7:0] hist_r;
  logic  [SEQ_CHARS-1:0][7:0] hcap_r;
  logic  [2:0]               hcnt_r;
  logic  [2:0]               copy_len_r;
  logic  [2:0]               copy_idx_r;
  logic                      idle_ok_r;
  logic  [31:0]              ms_div_r;
  logic  [15:0]              bdiv_r;
  logic  [15:0]              ms_cnt_r;
  logic  [15:0]              bit_cnt_r;
  logic                      ms_tick;
  logic                      bit_tick;
  logic                      wr_en;
  logic                      rd_en;
  logic                      addr_ok;
  logic                      go;
  logic                      start_rx;
  logic  [SEQ_CHARS-1:0][7:0] hnew;
  logic  [2:0]               hcnt_nxt;
  logic                      seq_hit;
  logic  [2:0]               hit_len;
  logic                      hunt_char;
  logic                      idle_start;
  logic                      end_msg;
  logic                      end_gap;
  logic                      end_max;
  logic  [9:0]               len_nxt;

  function automatic logic [2:0] pat_len(input logic [SEQ_CHARS-1:0] care);
    logic [2:0] l;
    l = 3'h0;
    for (int p = 0; p < SEQ_CHARS; p++) begin
      if (care[p]) begin
        l = 3'(p + 1);
      end
    end
    return l;
  endfunction

  // apb slave: zero wait states, error on unmapped offsets
  assign pready  = 1'b1;
  assign wr_en   = psel && penable && pwrite;
  assign rd_en   = psel && !pwrite;
  assign addr_ok = (paddr[1:0] == 2'h0) && ((paddr <= OFF_RD_DATA) ||
                   ((paddr >= OFF_SEQ_BASE) && (paddr < OFF_SEQ_END)));
  assign pslverr = psel && penable && !addr_ok;
  assign go      = wr_en && addr_ok && (paddr == OFF_CTRL) && pstrb[0] && pwdata[CTRL_GO];
  assign start_rx = (go || tx_done) && (state_r == ST_IDLE);

  always_comb begin
    prdata = 32'h0;
    if (rd_en) begin
      case (paddr)
        OFF_CTRL:      prdata = {25'h0, ctrl_r, 1'b0};
        OFF_STATUS:    prdata = {6'h0, len_r, 9'h0, cause_r, 1'b0, err_r, done_r,
                                 (state_r != ST_IDLE)};
        OFF_MSG_TO:    prdata = {16'h0, msg_to_r};
        OFF_RESP_TO:   prdata = {16'h0, resp_to_r};
        OFF_GAP:       prdata = {16'h0, gap_r};
        OFF_MAX_LEN:   prdata = {22'h0, max_len_r};
        OFF_BIT_DIV:   prdata = {16'h0, bit_div_r};
        OFF_IDLE_BITS: prdata = {16'h0, idle_bits_r};
        OFF_RD_IDX:    prdata = 32'(rd_idx_r);
        OFF_RD_DATA:   prdata = {24'h0, rd_data_r};
        default: begin
          if (addr_ok && paddr[2]) begin
            prdata = {15'h0, seq_r[paddr[4:3]].en, 3'h0, seq_r[paddr[4:3]].care,
                      seq_r[paddr[4:3]].chr[4]};
          end else if (addr_ok) begin
            prdata = seq_r[paddr[4:3]].chr[3:0];
          end
        end
      endcase
    end
  end

  // configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r      <= '0;
      seq_r       <= '0;
      msg_to_r    <= MSG_TO_RST;
      resp_to_r   <= RESP_TO_RST;
      gap_r       <= GAP_RST;
      max_len_r   <= MAX_LEN_RST;
      bit_div_r   <= BIT_DIV_RST;
      idle_bits_r <= IDLE_BITS_RST;
      rd_idx_r    <= '0;
    end else if (ce && wr_en && addr_ok) begin
      case (paddr)
        OFF_CTRL:      ctrl_r      <= ctrl_s'(pwdata[6:1]);
        OFF_MSG_TO:    msg_to_r    <= pwdata[15:0];
        OFF_RESP_TO:   resp_to_r   <= pwdata[15:0];
        OFF_GAP:       gap_r       <= pwdata[15:0];
        OFF_MAX_LEN:   max_len_r   <= (pwdata[9:0] < MAX_LEN_MIN) ? MAX_LEN_MIN
                                                                  : pwdata[9:0];
        OFF_BIT_DIV:   bit_div_r   <= pwdata[15:0];
        OFF_IDLE_BITS: idle_bits_r <= pwdata[15:0];
        OFF_RD_IDX:    rd_idx_r    <= pwdata[AW-1:0];
        default: begin
          if (paddr >= OFF_SEQ_BASE && paddr[2]) begin
            seq_r[paddr[4:3]].chr[4] <= pwdata[7:0];
            seq_r[paddr[4:3]].care   <= pwdata[SEQ_CARE +: SEQ_CHARS];
            seq_r[paddr[4:3]].en     <= pwdata[SEQ_EN];
          end else if (paddr >= OFF_SEQ_BASE) begin
            seq_r[paddr[4:3]].chr[3:0] <= pwdata;
          end
        end
      endcase
    end
  end

  // millisecond and bit-time ticks, restarted at each timer start
  assign ms_tick  = (ms_div_r == 32'(MS_DIV - 1));
  assign bit_tick = (bdiv_r == bit_div_r);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ms_div_r <= '0;
      bdiv_r   <= '0;
    end else if (ce) begin
      if (srst || start_rx || (state_r == ST_COPY) || idle_start || ms_tick) begin
        ms_div_r <= '0;
      end else begin
        ms_div_r <= ms_div_r + 32'h1;
      end
      if (srst || start_rx || rx_valid || bit_tick) begin
        bdiv_r <= '0;
      end else begin
        bdiv_r <= bdiv_r + 16'h1;
      end
    end
  end

  // pattern matching on the history extended by the arriving character
  always_comb begin
    logic       ok;
    logic [2:0] l;
    ok       = 1'b0;
    l        = 3'h0;
    hnew     = {hist_r[SEQ_CHARS-2:0], rx_data};
    hcnt_nxt = (hcnt_r == HIST_FULL) ? HIST_FULL : hcnt_r + 3'h1;
    seq_hit  = 1'b0;
    hit_len  = 3'h0;
    for (int s = 0; s < SEQ_NUM; s++) begin
      l  = pat_len(seq_r[s].care);
      ok = seq_r[s].en && (l != 3'h0) && (hcnt_nxt >= l);
      for (int p = 0; p < SEQ_CHARS; p++) begin
        if (3'(p) < l && seq_r[s].care[p] && hnew[l - 3'(p) - 3'h1] != seq_r[s].chr[p]) begin
          ok = 1'b0;
        end
      end
      if (ok && !seq_hit) begin
        seq_hit = 1'b1;
        hit_len = l;
      end
    end
  end

  assign hunt_char = (state_r == ST_HUNT) && rx_valid && (!ctrl_r.idle_en || idle_ok_r);
  assign len_nxt   = len_r + 10'h1;
  assign end_msg   = ctrl_r.msg_to_en && ms_tick && (ms_cnt_r == msg_to_r);
  assign end_gap   = ctrl_r.gap_en && bit_tick && !rx_valid && (bit_cnt_r >= gap_r);
  assign end_max   = ctrl_r.max_len_en && (len_r >= max_len_r);
  assign idle_start = (state_r == ST_HUNT) && ctrl_r.idle_en && !ctrl_r.seq_en && idle_ok_r;
  // history, idle detection and copy of the matched start characters
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hist_r     <= '0;
      hcap_r     <= '0;
      hcnt_r     <= '0;
      idle_ok_r  <= 1'b0;
      copy_len_r <= '0;
      copy_idx_r <= '0;
    end else if (ce) begin
      if (srst || start_rx) begin
        hist_r    <= '0;
        hcnt_r    <= '0;
        idle_ok_r <= 1'b0;
        copy_idx_r <= '0;
      end else if (state_r == ST_HUNT) begin
        if (rx_valid && !hunt_char) begin
          hcnt_r <= '0;
        end else if (hunt_char) begin
          hist_r <= hnew;
          hcnt_r <= hcnt_nxt;
          hcap_r <= hnew;
          copy_len_r <= ctrl_r.seq_en ? hit_len : 3'h1;
          copy_idx_r <= '0;
        end
        if (rx_valid && !(hunt_char && ctrl_r.seq_en && hcnt_nxt != HIST_FULL)) begin
          idle_ok_r <= 1'b0;
        end else if (bit_tick && bit_cnt_r >= idle_bits_r) begin
          idle_ok_r <= 1'b1;
        end
      end else if (state_r == ST_COPY) begin
        copy_idx_r <= copy_idx_r + 3'h1;
      end
    end
  end

  // message store, start characters first
  always_ff @(posedge pclk) begin
    if (ce && state_r == ST_COPY) begin
      mem[AW'(copy_idx_r)] <= hcap_r[copy_len_r - copy_idx_r - 3'h1];
    end else if (ce && state_r == ST_RECV && rx_valid && !end_max) begin
      mem[AW'(len_r)] <= rx_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_data_r <= '0;
    end else if (ce) begin
      rd_data_r <= mem[rd_idx_r];
    end
  end

  // elapsed milliseconds since the receive or message start, and bit times since the last character
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ms_cnt_r  <= '0;
      bit_cnt_r <= '0;
    end else if (ce) begin
      if (srst || start_rx || state_r == ST_COPY || idle_start) begin
        ms_cnt_r <= '0;
      end else if (ms_tick && ms_cnt_r != 16'hffff) begin
        ms_cnt_r <= ms_cnt_r + 16'h1;
      end
      if (srst || start_rx || rx_valid) begin
        bit_cnt_r <= '0;
      end else if (bit_tick && bit_cnt_r != 16'hffff) begin
        bit_cnt_r <= bit_cnt_r + 16'h1;
      end
    end
  end

  // receive sequencing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ST_IDLE;
      done_r  <= 1'b0;
      err_r   <= 1'b0;
      cause_r <= '0;
      len_r   <= '0;
    end else if (ce) begin
      if (srst) begin
        state_r <= ST_IDLE;
      end else begin
        case (state_r)
          ST_IDLE: begin
            if (start_rx) begin
              state_r <= ST_HUNT;
              done_r  <= 1'b0;
              err_r   <= 1'b0;
              cause_r <= '0;
              len_r   <= '0;
            end
          end
          ST_HUNT: begin
            if (hunt_char && (!ctrl_r.seq_en || seq_hit)) begin
              state_r <= ST_COPY;
            end else if (idle_start) begin
              state_r <= ST_RECV;
            end else if (ctrl_r.resp_to_en && hcnt_r == 3'h0 && !rx_valid && ms_tick &&
                         ms_cnt_r == resp_to_r) begin
              state_r <= ST_IDLE;
              err_r   <= 1'b1;
            end
          end
          ST_COPY: begin
            len_r <= len_nxt;
            if (copy_idx_r + 3'h1 == copy_len_r) begin
              state_r <= ST_RECV;
            end
          end
          ST_RECV: begin
            // response timeout plays no part once started
            if (end_msg || end_gap || end_max) begin
              state_r <= ST_IDLE;
              done_r  <= 1'b1;
              cause_r <= {end_max, end_gap, end_msg};
            end else if (rx_valid) begin
              len_r <= len_nxt;
              if (len_nxt == 10'(DEPTH - 1)) begin
                state_r <= ST_IDLE;
                done_r  <= 1'b1;
              end
            end
          end
          default: state_r <= ST_IDLE;
        endcase
      end
    end
  end

  assign rx_busy   = (state_r != ST_IDLE);
  assign msg_done  = done_r;
  assign msg_error = err_r;
endmodule

// ---- rtl/rx_framer_pkg.sv ----
// constants, register map and carrier types of the receive message framer
// assumes a 32-bit apb slave at 20 mhz and a character source on the same clock
package rx_framer_pkg;
  localparam int          CLK_HZ        = 20000000;
  localparam int          MS_NS         = 1000000;
  localparam int          CLK_NS        = 1000000000 / CLK_HZ;
  localparam int          MS_CYCLES     = MS_NS / CLK_NS;
  localparam int          SEQ_NUM       = 4;
  localparam int          SEQ_CHARS     = 5;

  localparam logic [11:0] OFF_CTRL      = 12'h000;
  localparam logic [11:0] OFF_STATUS    = 12'h004;
  localparam logic [11:0] OFF_MSG_TO    = 12'h008;
  localparam logic [11:0] OFF_RESP_TO   = 12'h00c;
  localparam logic [11:0] OFF_GAP       = 12'h010;
  localparam logic [11:0] OFF_MAX_LEN   = 12'h014;
  localparam logic [11:0] OFF_BIT_DIV   = 12'h018;
  localparam logic [11:0] OFF_IDLE_BITS = 12'h01c;
  localparam logic [11:0] OFF_RD_IDX    = 12'h020;
  localparam logic [11:0] OFF_RD_DATA   = 12'h024;
  localparam logic [11:0] OFF_SEQ_BASE  = 12'h040;
  localparam logic [11:0] OFF_SEQ_END   = 12'h060;

  localparam int          CTRL_GO       = 0;
  localparam int          STS_BUSY      = 0;
  localparam int          STS_DONE      = 1;
  localparam int          STS_ERR       = 2;
  localparam int          STS_CAUSE     = 4;
  localparam int          STS_LEN       = 16;
  localparam int          SEQ_CARE      = 8;
  localparam int          SEQ_EN        = 16;

  localparam logic [15:0] MSG_TO_RST    = 16'h00c8;
  localparam logic [15:0] RESP_TO_RST   = 16'h00c8;
  localparam logic [15:0] GAP_RST       = 16'h000c;
  localparam logic [9:0]  MAX_LEN_RST   = 10'h3ff;
  localparam logic [9:0]  MAX_LEN_MIN   = 10'h001;
  localparam logic [15:0] IDLE_BITS_RST = 16'h000c;
  localparam logic [2:0]  HIST_FULL     = 3'h5;

  // control enables, one bit each, from bit 1 of the control word upward
  typedef struct packed {
    logic resp_to_en;
    logic max_len_en;
    logic gap_en;
    logic msg_to_en;
    logic idle_en;
    logic seq_en;
  } ctrl_s;

  typedef struct packed {
    logic                           en;
    logic [SEQ_CHARS-1:0]           care;
    logic [SEQ_CHARS-1:0][7:0]      chr;
  } seq_s;

  typedef enum logic [1:0] {ST_IDLE, ST_HUNT, ST_COPY, ST_RECV} state_e;
endpackage

// ---- sim/serial_rx_message_framer_assertions.sv ----
// port checks of the receive message framer, bound onto every instance
// assumes one clock pclk and the asynchronous active-low reset presetn
`timescale 1ns/1ns
module serial_rx_message_framer_checker (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        ce,
  input wire logic        srst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        rx_valid,
  input wire logic [7:0]  rx_data,
  input wire logic        tx_done,
  input wire logic        rx_busy,
  input wire logic        msg_done,
  input wire logic        msg_error
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic hole;
  logic go_wr;
  assign hole  = paddr[1:0] != 2'b00 || (paddr >= 12'h028 && paddr < 12'h040) || paddr >= 12'h060;
  assign go_wr = psel && penable && pwrite && paddr == 12'h000 && pwdata[0] && pstrb[0];
  AST_PREADY: assert property (pready)
    else $error("pready low");
  AST_HOLE: assert property (psel && penable && hole |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  AST_ERR_PHASE: assert property (pslverr |-> psel && penable)
    else $error("pslverr outside access phase");
  AST_GO_START: assert property (go_wr && ce && !srst && !rx_busy |=> rx_busy)
    else $error("go did not start receive");
  AST_TX_START: assert property (tx_done && ce && !srst && !rx_busy |=>
    rx_busy && !msg_done && !msg_error) else $error("tx_done did not start receive");
  AST_END_IDLE: assert property ($rose(msg_done) |-> !rx_busy && $past(rx_busy))
    else $error("done without ending a message");
  AST_ERR_IDLE: assert property ($rose(msg_error) |-> !rx_busy && $past(rx_busy))
    else $error("error without ending a receive");
  AST_EXCL: assert property (!(msg_done && msg_error))
    else $error("done and error together");
  AST_DONE_HOLD: assert property ($fell(msg_done) |-> rx_busy || $past(srst))
    else $error("done dropped without a new start");
  AST_SRST: assert property (srst && ce |=> !rx_busy)
    else $error("sync reset left receive busy");
  AST_FREEZE: assert property (!ce |=> $stable(rx_busy) && $stable(msg_done))
    else $error("state moved while clock enable low");
  COV_DONE: cover property ($rose(msg_done));
  COV_ERR: cover property ($rose(msg_error));
  COV_TX: cover property (tx_done && !rx_busy);
  COV_HOLE: cover property (pslverr);
endmodule

bind serial_rx_message_framer serial_rx_message_framer_checker chk_u (
  .pclk(pclk), .presetn(presetn), .ce(ce), .srst(srst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .rx_valid(rx_valid), .rx_data(rx_data),
  .tx_done(tx_done), .rx_busy(rx_busy), .msg_done(msg_done), .msg_error(msg_error));

// ---- sim/rx_char_source.sv ----
// remote sender model: queued characters, each followed by a set idle gap
// assumes pclk is shared with the framer; no pull on the data line
`timescale 1ns/1ns
module rx_char_source (
  input  wire logic       pclk,
  input  wire logic       presetn,
  output logic            rx_valid,
  output logic [7:0]      rx_data
);
  logic [15:0] q[$];
  int          wait_r;
  task automatic push(input logic [7:0] c, input logic [7:0] g);
    q.push_back({g, c});
  endtask
  // released line shows the inverse of the last value
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_valid <= 1'b0;
      rx_data  <= 8'h00;
      wait_r   <= 0;
    end else if (wait_r == 0 && q.size() > 0) begin
      rx_valid <= 1'b1;
      rx_data  <= q[0][7:0];
      wait_r   <= int'(q[0][15:8]);
      void'(q.pop_front());
    end else begin
      rx_valid <= 1'b0;
      rx_data  <= ~rx_data;
      if (wait_r > 0) wait_r <= wait_r - 1;
    end
  end
endmodule

// ---- sim/serial_rx_message_framer_tb.sv ----
// self-checking bench of the receive message framer over apb
// assumes the sender model and the bound checker are compiled before it
`timescale 1ns/1ns
module serial_rx_message_framer_tb import rx_framer_pkg::*;;
  typedef struct packed {
    logic [6:0]      ctrl;
    logic [7:0]      lim;
    logic [7:0]      gap;
    logic [2:0]      n;
    logic [6:0][7:0] ch;
    logic [31:0]     exp;
  } row_s;
  logic        pclk = 0, presetn = 0, ce = 1, srst = 0, psel = 0, penable = 0, pwrite = 0;
  logic        tx_done = 0, pready, pslverr, rx_valid, rx_busy, msg_done, msg_error, er;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0]  pstrb = 4'hf;
  logic [7:0]  rx_data;
  int          mismatches = 0, checked = 0;
  // every case enables a real end condition
  row_s rows [6] = '{
    '{7'h13, 8'h00, 8'h08, 3'h7, 56'h556a1214181c33, 32'h00060022},
    '{7'h13, 8'h00, 8'h08, 3'h4, 56'h176a6a44000000, 32'h00040022},
    '{7'h33, 8'h06, 8'h08, 3'h7, 56'h6a44a5d21c0102, 32'h00060042},
    '{7'h10, 8'h00, 8'h08, 3'h2, 56'h11220000000000, 32'h00020022},
    '{7'h51, 8'h03, 8'h08, 3'h0, 56'h0, 32'h00000004},
    '{7'h49, 8'h02, 8'h1e, 3'h3, 56'h21222300000000, 32'h00020012}};
  serial_rx_message_framer #(.MS_DIV(20)) dut_u (
    .pclk(pclk), .presetn(presetn), .ce(ce), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_valid(rx_valid), .rx_data(rx_data),
    .tx_done(tx_done), .rx_busy(rx_busy), .msg_done(msg_done), .msg_error(msg_error));
  rx_char_source src_u (.pclk(pclk), .presetn(presetn), .rx_valid(rx_valid), .rx_data(rx_data));
  always #25 pclk = ~pclk;
  task automatic complete_run;
    $display("checked=%0d mismatches=%0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      mismatches++;
      complete_run();
    end
  endtask
  task automatic settle;
    int n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while ((rx_busy !== 1'b0 || src_u.q.size() != 0 || src_u.wait_r != 0) && n < 2000);
    if (n >= 2000) begin
      mismatches++;
      complete_run();
    end
    apb(1'b0, OFF_STATUS, 32'h0);
  endtask
  task automatic run_row(input row_s r);
    apb(1'b1, OFF_MAX_LEN, {24'h0, r.lim});
    apb(1'b1, OFF_MSG_TO, {24'h0, r.lim});
    apb(1'b1, OFF_RESP_TO, {24'h0, r.lim});
    apb(1'b1, OFF_CTRL, {25'h0, r.ctrl});
    if (!r.ctrl[0]) begin
      tx_done <= 1'b1;
      @(posedge pclk);
      tx_done <= 1'b0;
    end
    for (int i = 0; i < r.n; i++) src_u.push(r.ch[6 - i], r.gap);
    settle();
  endtask
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b1, OFF_BIT_DIV, 32'h3);
    apb(1'b1, OFF_GAP, 32'h4);
    apb(1'b1, 12'h040, 32'h0000006a);
    apb(1'b1, 12'h044, 32'h0001111c);
    apb(1'b1, 12'h048, 32'h006a6a00);
    apb(1'b1, 12'h04c, 32'h00010600);
    foreach (rows[i]) begin
      run_row(rows[i]);
      chk(rd, rows[i].exp);
      chk({30'h0, msg_error, msg_done}, {30'h0, rows[i].exp[2:1]});
    end
    run_row(rows[1]);
    apb(1'b1, OFF_RD_IDX, 32'h0);
    apb(1'b0, OFF_RD_DATA, 32'h0);
    chk(rd, 32'h17);
    apb(1'b1, OFF_RD_IDX, 32'h3);
    apb(1'b0, OFF_RD_DATA, 32'h0);
    chk(rd, 32'h44);
    // idle first, then a sequence whose characters come closer than the idle time
    apb(1'b1, OFF_IDLE_BITS, 32'h6);
    apb(1'b1, OFF_CTRL, 32'h17);
    src_u.push(8'h55, 8'h28);
    src_u.push(8'h17, 8'h08);
    src_u.push(8'h6a, 8'h08);
    src_u.push(8'h6a, 8'h08);
    src_u.push(8'h44, 8'h08);
    settle();
    chk(rd, 32'h00040022);
    // idle alone starts; message timer runs from that start
    apb(1'b1, OFF_MSG_TO, 32'h2);
    apb(1'b1, OFF_CTRL, 32'h0d);
    repeat (75) @(posedge pclk);
    chk({31'h0, rx_busy}, 32'h1);
    settle();
    chk(rd, 32'h00000012);
    apb(1'b0, 12'h030, 32'h0);
    chk({31'h0, er}, 32'h1);
    chk(rd, 32'h0);
    apb(1'b1, OFF_CTRL, 32'h11);
    ce <= 1'b0;
    repeat (3) @(posedge pclk);
    chk({31'h0, rx_busy}, 32'h1);
    ce   <= 1'b1;
    srst <= 1'b1;
    @(posedge pclk);
    srst <= 1'b0;
    @(posedge pclk);
    chk({31'h0, rx_busy}, 32'h0);
    apb(1'b1, OFF_MAX_LEN, 32'h0);
    apb(1'b0, OFF_MAX_LEN, 32'h0);
    chk(rd, 32'h1);
    apb(1'b1, OFF_MSG_TO, 32'hffff);
    apb(1'b0, OFF_MSG_TO, 32'h0);
    chk(rd, 32'hffff);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, OFF_MSG_TO, 32'h0);
    chk(rd, 32'h00c8);
    apb(1'b0, OFF_RESP_TO, 32'h0);
    chk(rd, 32'h00c8);
    apb(1'b0, OFF_GAP, 32'h0);
    chk(rd, 32'h000c);
    complete_run();
  end
endmodule
